// ===== sbc_single_channel.sv
// sbc_single_channel: register port, sample pacing and crossing for the aux byte channel
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sbc_single_channel
   import sbc_pkg::*;
#(
   parameter int SAMPLE_CYC_P = SAMPLE_CYC
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic link_clk_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic [7:0] burst3_byte_o,
   output logic irq_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   localparam int CW = $clog2(SAMPLE_CYC_P + 1);

   // =====================================================================
   // state
   typedef struct packed {
      logic [1:0] bank;
      logic [7:0] b3wb;
      logic [7:0] tadr;
      logic [7:0] treg;
      logic [7:0] ctrl;
      logic [7:0] wbyte;
      logic [7:0] rbyte;
      logic [3:0] odr;
      logic [7:0] dlyc;
      logic done;
      logic nack;
      logic busy;
      logic [CW-1:0] base;
      logic [3:0] odr_cnt;
      logic [4:0] dly_cnt;
      logic go_tgl;
      logic [6:0] l_adr;
      logic l_rnw;
      logic l_skip;
      logic [7:0] l_reg;
      logic [7:0] l_wd;
      logic done_m;
      logic done_s;
      logic done_seen;
      logic [7:0] rdata;
      logic irq;
   } sbc_core_t;

   sbc_core_t st_r;
   sbc_core_t st_nxt;
   logic in_aux;
   logic wr_ctrl;
   logic st_rd;
   logic done_edge;
   logic base_tick;
   logic smp_tick;
   logic slot;
   logic launch;
   logic [7:0] rd_val;

   sbc_xfer_if x ();

   // =====================================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      in_aux = st_r.bank == BANK_AUX;
      wr_ctrl = reg_wr_i && in_aux && reg_addr_i == A_SINGLE_CHANNEL_CONTROL;
      st_rd = reg_rd_i && in_aux && reg_addr_i == A_SINGLE_STATUS;
      done_edge = st_r.done_s != st_r.done_seen;

      // sample pacing: base period, then output-rate divider, then channel delay
      base_tick = st_r.base == CW'(SAMPLE_CYC_P - 1);
      smp_tick = base_tick && st_r.odr_cnt >= st_r.odr;
      slot = !st_r.dlyc[B_DLY_EN] || st_r.dly_cnt == 5'h00;
      launch = smp_tick && slot && st_r.ctrl[B_GO] && !st_r.busy;

      st_nxt.base = base_tick ? '0 : st_r.base + CW'(1);
      if (base_tick) begin
         st_nxt.odr_cnt = smp_tick ? 4'h0 : st_r.odr_cnt + 4'h1;
      end
      if (smp_tick) begin
         // a shrunk delay field must not strand the counter above it
         if (st_r.dly_cnt >= st_r.ctrl[4:0]) begin
            st_nxt.dly_cnt = 5'h00;
         end else begin
            st_nxt.dly_cnt = st_r.dly_cnt + 5'h01;
         end
      end

      // =====================================================================
      // launch: settings are frozen so software edits cannot tear a frame
      if (launch) begin
         st_nxt.busy = 1'b1;
         st_nxt.go_tgl = !st_r.go_tgl;
         st_nxt.l_adr = st_r.tadr[6:0];
         st_nxt.l_rnw = st_r.tadr[B_DIR];
         st_nxt.l_skip = st_r.ctrl[B_SKIP];
         st_nxt.l_reg = st_r.treg;
         st_nxt.l_wd = st_r.wbyte;
      end

      // =====================================================================
      // completion back from the link side
      st_nxt.done_m = x.done_tgl;
      st_nxt.done_s = st_r.done_m;
      if (st_rd) begin
         st_nxt.done = 1'b0;
         st_nxt.nack = 1'b0;
      end
      if (done_edge) begin
         // result words are stable: the link side holds them until the next go
         st_nxt.done_seen = st_r.done_s;
         st_nxt.busy = 1'b0;
         st_nxt.ctrl[B_GO] = 1'b0;
         st_nxt.done = 1'b1;
         st_nxt.nack = x.nack;
         if (st_r.l_rnw) begin
            st_nxt.rbyte = x.rdata;
         end
      end

      // =====================================================================
      // register writes; a write to control overrides the self clear
      if (reg_wr_i) begin
         if (reg_addr_i == A_BANK_SELECTOR) begin
            st_nxt.bank = reg_wdata_i[B_BANK+1:B_BANK];
         end else if (in_aux) begin
            case (reg_addr_i)
               A_BURST3_WRITE_BYTE: begin
                  st_nxt.b3wb = reg_wdata_i;
               end
               A_SINGLE_TARGET_ADDRESS: begin
                  st_nxt.tadr = reg_wdata_i;
               end
               A_SINGLE_TARGET_REGISTER: begin
                  st_nxt.treg = reg_wdata_i;
               end
               A_SINGLE_CHANNEL_CONTROL: begin
                  st_nxt.ctrl = reg_wdata_i;
               end
               A_SINGLE_WRITE_BYTE: begin
                  st_nxt.wbyte = reg_wdata_i;
               end
               A_MASTER_OUTPUT_RATE_CONFIG: begin
                  st_nxt.odr = reg_wdata_i[3:0];
               end
               A_MASTER_DELAY_CONTROL: begin
                  st_nxt.dlyc = reg_wdata_i;
               end
               default: begin
               end
            endcase
         end
      end

      // =====================================================================
      // register reads; unmapped or hidden offsets read zero
      rd_val = RST_BYTE;
      if (reg_addr_i == A_BANK_SELECTOR) begin
         rd_val = {2'b00, st_r.bank, 4'h0};
      end else if (in_aux) begin
         case (reg_addr_i)
            A_BURST3_WRITE_BYTE: begin
               rd_val = st_r.b3wb;
            end
            A_SINGLE_TARGET_ADDRESS: begin
               rd_val = st_r.tadr;
            end
            A_SINGLE_TARGET_REGISTER: begin
               rd_val = st_r.treg;
            end
            A_SINGLE_CHANNEL_CONTROL: begin
               rd_val = st_r.ctrl;
            end
            A_SINGLE_WRITE_BYTE: begin
               rd_val = st_r.wbyte;
            end
            A_SINGLE_READ_BYTE: begin
               rd_val = st_r.rbyte;
            end
            A_SINGLE_STATUS: begin
               rd_val = {1'b0, st_r.done, 1'b0, st_r.nack, 3'b000, st_r.busy};
            end
            A_MASTER_OUTPUT_RATE_CONFIG: begin
               rd_val = {4'h0, st_r.odr};
            end
            A_MASTER_DELAY_CONTROL: begin
               rd_val = st_r.dlyc;
            end
            default: begin
               rd_val = RST_BYTE;
            end
         endcase
      end
      st_nxt.rdata = reg_rd_i ? rd_val : RST_BYTE;

      // =====================================================================
      // interrupt level
      st_nxt.irq = st_nxt.done && st_nxt.ctrl[B_IRQ_EN];
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =====================================================================
   // outputs and link side
   assign reg_rdata_o = st_r.rdata;
   assign burst3_byte_o = st_r.b3wb;
   assign irq_o = st_r.irq;
   assign x.go_tgl = st_r.go_tgl;
   assign x.tgt_addr = st_r.l_adr;
   assign x.rnw = st_r.l_rnw;
   assign x.skip_reg = st_r.l_skip;
   assign x.reg_addr = st_r.l_reg;
   assign x.wdata = st_r.l_wd;

   sbc_i2c_engine i_sbc_i2c_engine (
      .link_clk_i(link_clk_i),
      .sys_rst_i(sys_rst_i),
      .bus(x.link),
      .scl_i(scl_i),
      .scl_o(scl_o),
      .scl_oe_o(scl_oe_o),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o)
   );

   // =====================================================================
   // checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_go_self_clear;
      done_edge && !wr_ctrl |=> !st_r.ctrl[B_GO];
   endproperty
   a_go_self_clear: assert property (p_go_self_clear)
      else $error("go bit not cleared after completion");

   property p_read_capture;
      done_edge && st_r.l_rnw |=> st_r.rbyte == $past(x.rdata);
   endproperty
   a_read_capture: assert property (p_read_capture)
      else $error("read byte not stored");

   property p_irq_raise;
      done_edge && st_r.ctrl[B_IRQ_EN] && !wr_ctrl |=> irq_o ##1 (irq_o || !st_r.done);
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("completion did not raise interrupt");

   property p_irq_quiet;
      $fell(st_r.ctrl[B_IRQ_EN]) |-> !irq_o;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("interrupt with enable clear");

   property p_launch_toggle;
      launch |=> st_r.busy && st_r.go_tgl != $past(st_r.go_tgl);
   endproperty
   a_launch_toggle: assert property (p_launch_toggle)
      else $error("launch did not start a transfer");

   property p_capture_addr;
      launch |=> st_r.l_adr == $past(st_r.tadr[6:0]) && st_r.l_rnw == $past(st_r.tadr[B_DIR]);
   endproperty
   a_capture_addr: assert property (p_capture_addr)
      else $error("target address or direction not captured");

   property p_skip_capture;
      launch |=> st_r.l_skip == $past(st_r.ctrl[B_SKIP]) && st_r.l_reg == $past(st_r.treg);
   endproperty
   a_skip_capture: assert property (p_skip_capture)
      else $error("register phase setting not captured");

   property p_delay_slot;
      launch && st_r.dlyc[B_DLY_EN] |-> st_r.dly_cnt == 5'h00;
   endproperty
   a_delay_slot: assert property (p_delay_slot)
      else $error("delayed channel launched outside its slot");

   property p_bank_hide;
      reg_rd_i && st_r.bank != BANK_AUX && reg_addr_i != A_BANK_SELECTOR
         |=> reg_rdata_o == RST_BYTE;
   endproperty
   a_bank_hide: assert property (p_bank_hide)
      else $error("aux register visible outside its bank");

   property p_read_only;
      reg_wr_i && reg_addr_i == A_SINGLE_READ_BYTE && !done_edge
         |=> st_r.rbyte == $past(st_r.rbyte);
   endproperty
   a_read_only: assert property (p_read_only)
      else $error("read byte changed by a write");

   property p_one_at_a_time;
      st_r.busy == (st_r.go_tgl != st_r.done_seen);
   endproperty
   a_one_at_a_time: assert property (p_one_at_a_time)
      else $error("launch and completion out of step");

   property p_go_hold;
      st_r.ctrl[B_GO] && !done_edge && !reg_wr_i |=> st_r.ctrl[B_GO];
   endproperty
   a_go_hold: assert property (p_go_hold)
      else $error("go bit dropped before completion");

   property p_wbyte_capture;
      launch |=> st_r.l_wd == $past(st_r.wbyte);
   endproperty
   a_wbyte_capture: assert property (p_wbyte_capture)
      else $error("write byte not captured");

   property p_bank_write;
      reg_wr_i && reg_addr_i == A_BANK_SELECTOR
         |=> st_r.bank == $past(reg_wdata_i[B_BANK+1:B_BANK]);
   endproperty
   a_bank_write: assert property (p_bank_write)
      else $error("bank field not taken from write");

   property p_rdata_one_cycle;
      !reg_rd_i |=> reg_rdata_o == RST_BYTE;
   endproperty
   a_rdata_one_cycle: assert property (p_rdata_one_cycle)
      else $error("read data outside its cycle");
endmodule : sbc_single_channel
`default_nettype wire

// ===== sbc_pkg.sv
// sbc_pkg: register map, field positions, reset values and timing of the aux byte channel
// Function
// - the third burst channel keeps an 8-bit write byte that it sends when set to write.
// - bit 7 of the target address selects a read when 1 and a write when 0.
// - bits 6 to 0 of the target address hold the 7-bit bus address used on the wire.
// - the single channel moves exactly one data byte per transfer, with no length field.
// - the 8-bit target register is sent as the place where the data transfer begins.
// - with go bit 7 set a transfer runs at the sample rate, filling or sending the data byte.
// - the go bit clears itself once its one transfer is complete.
// - with bit 6 set completion raises the interrupt, with bit 6 clear it raises none.
// - with bit 5 set the register phase is left out and only the data byte moves.
// - a delay-enabled channel runs only once every 1 plus delay-field samples.
// - the received byte shows in a read-only register that resets to zero.
// - bank field bits 5 to 4 choose user bank 0 to 3; the other bits are reserved.
package sbc_pkg;
   // =====================================================================
   // register offsets
   localparam logic [6:0] A_BURST3_WRITE_BYTE = 7'h12;
   localparam logic [6:0] A_SINGLE_TARGET_ADDRESS = 7'h13;
   localparam logic [6:0] A_SINGLE_TARGET_REGISTER = 7'h14;
   localparam logic [6:0] A_SINGLE_CHANNEL_CONTROL = 7'h15;
   localparam logic [6:0] A_SINGLE_WRITE_BYTE = 7'h16;
   localparam logic [6:0] A_SINGLE_READ_BYTE = 7'h17;
   localparam logic [6:0] A_SINGLE_STATUS = 7'h18;
   localparam logic [6:0] A_MASTER_OUTPUT_RATE_CONFIG = 7'h00;
   localparam logic [6:0] A_MASTER_DELAY_CONTROL = 7'h02;
   localparam logic [6:0] A_BANK_SELECTOR = 7'h7F;
   localparam logic [1:0] BANK_AUX = 2'h3;
   // =====================================================================
   // field positions and reset value
   localparam int B_DIR = 7;
   localparam int B_GO = 7;
   localparam int B_IRQ_EN = 6;
   localparam int B_SKIP = 5;
   localparam int B_DLY_EN = 4;
   localparam int B_BANK = 4;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // =====================================================================
   // timing
   localparam int SAMPLE_US = 1000;
   localparam int CORE_MHZ = 25;
   localparam int SAMPLE_CYC = SAMPLE_US * CORE_MHZ;
   localparam int QUARTER_NS = 625;
   localparam int LINK_PS = 32000;
   localparam int QUARTER_CYC = (QUARTER_NS * 1000 + LINK_PS - 1) / LINK_PS;
   // =====================================================================
   // link sequencer
   typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_ACK, S_STOP} sbc_lstate_t;
   typedef enum logic [1:0] {K_ADR, K_REG, K_DAT} sbc_kind_t;
endpackage : sbc_pkg

// ===== sbc_xfer_if.sv
// sbc_xfer_if: transfer request and result between core side and link side
`timescale 1ns/1ps
`default_nettype none
interface sbc_xfer_if;
   logic go_tgl;
   logic [6:0] tgt_addr;
   logic rnw;
   logic skip_reg;
   logic [7:0] reg_addr;
   logic [7:0] wdata;
   logic done_tgl;
   logic [7:0] rdata;
   logic nack;
   modport core (output go_tgl, tgt_addr, rnw, skip_reg, reg_addr, wdata,
                 input done_tgl, rdata, nack);
   modport link (input go_tgl, tgt_addr, rnw, skip_reg, reg_addr, wdata,
                 output done_tgl, rdata, nack);
endinterface : sbc_xfer_if
`default_nettype wire

// ===== sbc_i2c_engine.sv
// sbc_i2c_engine: one-byte I2C master frame sequencer on the link clock
`timescale 1ns/1ps
`default_nettype none
module sbc_i2c_engine
   import sbc_pkg::*;
#(
   parameter int QCYC = QUARTER_CYC
) (
   input wire logic link_clk_i,
   input wire logic sys_rst_i,
   sbc_xfer_if.link bus,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   localparam int QW = $clog2(QCYC + 1);
   typedef struct packed {
      logic rst_m; logic rst_s; logic go_m; logic go_s; logic go_seen;
      logic sda_m; logic sda_s; logic scl_m; logic scl_s;
      sbc_lstate_t state; sbc_kind_t kind; logic in_read;
      logic [1:0] ph; logic [QW-1:0] div; logic [2:0] bitn; logic [7:0] shft;
      logic nack; logic [7:0] rdata; logic done_tgl; logic scl_low; logic sda_low;
   } sbc_link_t;
   sbc_link_t st_r, st_nxt;
   logic rd, stall, tick;
   // =====================================================================
   // frame sequencer
   always_comb begin
      st_nxt = st_r;
      rd = st_r.in_read && st_r.kind == K_DAT;
      stall = st_r.ph == 2'd1 && !st_r.scl_s;
      tick = !stall && st_r.div == QW'(QCYC - 1);
      st_nxt.rst_m = sys_rst_i;
      st_nxt.rst_s = st_r.rst_m;
      st_nxt.go_m = bus.go_tgl;
      st_nxt.go_s = st_r.go_m;
      st_nxt.sda_m = sda_i;
      st_nxt.sda_s = st_r.sda_m;
      st_nxt.scl_m = scl_i;
      st_nxt.scl_s = st_r.scl_m;
      if (st_r.rst_s) begin
         st_nxt.state = S_IDLE;
         st_nxt.go_seen = 1'b0;
         st_nxt.done_tgl = 1'b0;
         st_nxt.nack = 1'b0;
         st_nxt.rdata = RST_BYTE;
         st_nxt.shft = RST_BYTE;
         st_nxt.ph = 2'd0;
         st_nxt.div = '0;
         st_nxt.kind = K_ADR;
         st_nxt.in_read = 1'b0;
         st_nxt.bitn = 3'd7;
      end else if (st_r.state == S_IDLE) begin
         if (st_r.go_s != st_r.go_seen) begin
            st_nxt.go_seen = st_r.go_s;
            st_nxt.state = S_START;
            st_nxt.in_read = bus.rnw && bus.skip_reg;
            st_nxt.nack = 1'b0;
            st_nxt.ph = 2'd0;
            st_nxt.div = '0;
         end
      end else begin
         st_nxt.div = (stall || tick) ? '0 : st_r.div + QW'(1);
         if (tick) begin
            st_nxt.ph = st_r.ph + 2'd1;
            if (st_r.ph == 2'd2 && rd && st_r.state == S_BIT) st_nxt.shft = {st_r.shft[6:0], st_r.sda_s};
            if (st_r.ph == 2'd2 && st_r.state == S_ACK && !rd) st_nxt.nack = st_r.sda_s;
            if (st_r.ph == 2'd3) begin
               unique case (st_r.state)
                  S_START: begin
                     st_nxt.state = S_BIT;
                     st_nxt.kind = K_ADR;
                     st_nxt.bitn = 3'd7;
                     st_nxt.shft = {bus.tgt_addr, st_r.in_read};
                  end
                  S_BIT: begin
                     if (!rd) st_nxt.shft = {st_r.shft[6:0], 1'b0};
                     if (st_r.bitn == 3'd0) st_nxt.state = S_ACK;
                     else st_nxt.bitn = st_r.bitn - 3'd1;
                  end
                  S_ACK: begin
                     st_nxt.bitn = 3'd7;
                     st_nxt.state = S_BIT;
                     if (st_r.nack) st_nxt.state = S_STOP;
                     else if (st_r.kind == K_DAT) begin
                        if (st_r.in_read) st_nxt.rdata = st_r.shft;
                        st_nxt.state = S_STOP;
                     end else if (st_r.kind == K_REG && bus.rnw) begin
                        st_nxt.in_read = 1'b1;
                        st_nxt.state = S_START;
                     end else if (st_r.kind == K_ADR && !bus.skip_reg && !st_r.in_read) begin
                        st_nxt.kind = K_REG;
                        st_nxt.shft = bus.reg_addr;
                     end else begin
                        st_nxt.kind = K_DAT;
                        st_nxt.shft = bus.wdata;
                     end
                  end
                  S_STOP: begin
                     st_nxt.state = S_IDLE;
                     st_nxt.done_tgl = !st_r.done_tgl;
                  end
                  default: st_nxt.state = S_IDLE;
               endcase
            end
         end
      end
      // outputs follow the next phase so they leave the flops aligned with it
      st_nxt.scl_low = st_nxt.state != S_IDLE &&
         (st_nxt.ph == 2'd0 || (st_nxt.ph == 2'd3 && st_nxt.state != S_STOP));
      if (st_nxt.state == S_START) st_nxt.sda_low = st_nxt.ph[1];
      else if (st_nxt.state == S_STOP) st_nxt.sda_low = !st_nxt.ph[1];
      else if (st_nxt.state == S_BIT)
         st_nxt.sda_low = !(st_nxt.in_read && st_nxt.kind == K_DAT) && !st_nxt.shft[7];
      else st_nxt.sda_low = 1'b0;
   end
   always_ff @(posedge link_clk_i) begin
      st_r <= st_nxt;
   end
   assign bus.done_tgl = st_r.done_tgl;
   assign bus.rdata = st_r.rdata;
   assign bus.nack = st_r.nack;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = st_r.scl_low;
   assign sda_oe_o = st_r.sda_low;
endmodule : sbc_i2c_engine
`default_nettype wire

// ===== sbc_i2c_target.sv
// sbc_i2c_target: behavioural I2C target seen by the aux byte channel
`timescale 1ns/1ps
`default_nettype none
module sbc_i2c_target #(
   parameter logic [6:0] ADDR = 7'h2A,
   parameter logic [7:0] RBYTE = 8'hC5
) (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic slow_i,
   output logic sda_pull_o,
   output logic scl_pull_o
);
   logic [7:0] sh;
   logic [7:0] got [0:3];
   logic rd, ackph, tx, first, fin;
   int nb, nby;
   wire logic sda_d;
   // =====================================================================
   // framing
   // delayed copy: a data edge beside a falling clock is not start or stop
   assign #2 sda_d = sda_i;
   initial begin
      {sda_pull_o, scl_pull_o, rd, ackph, tx, first, fin} = 7'h01;
      nb = 0;
      nby = 0;
   end
   always @(negedge sda_d) if (scl_i) begin
      if (fin) nby = 0;
      {fin, first, tx, ackph, nb} = {4'h4, 32'd0};
   end
   always @(posedge sda_d) if (scl_i) {fin, tx, ackph, sda_pull_o} = 4'h8;
   always @(posedge scl_i) if (nb < 8) begin
      sh = {sh[6:0], sda_i};
      nb++;
   end
   always @(negedge scl_i) begin
      if (ackph) begin
         {ackph, tx, rd, nb} = {1'b0, rd, 1'b0, 32'd0};
         sda_pull_o = tx & !RBYTE[7];
      end else if (nb == 8) begin
         ackph = 1;
         if (tx) sda_pull_o = 0;
         else begin
            got[nby] = sh;
            nby++;
            sda_pull_o = !first || sh[7:1] == ADDR;
            rd = first & sh[0] & (sh[7:1] == ADDR);
            first = 0;
         end
      end else if (tx) sda_pull_o = !RBYTE[7 - nb];
   end
   // slow mode stretches every low phase of the clock
   always @(negedge scl_i) if (slow_i) begin
      scl_pull_o = 1;
      #1500 scl_pull_o = 0;
   end
endmodule : sbc_i2c_target
`default_nettype wire

// ===== test_aux_i2c_single_byte_channel.sv
// test_aux_i2c_single_byte_channel: self-checking bench of the aux byte channel
`timescale 1ns/1ps
`default_nettype none
module test_aux_i2c_single_byte_channel;
   import sbc_pkg::*;
   localparam logic [6:0] TADR = 7'h2A;
   localparam logic [7:0] TBYTE = 8'hC5;
   logic clk = 0, lclk = 0, rst = 1, wr = 0, rd = 0, slow = 0, irq;
   logic scl_oe, sda_oe, scl_pull, sda_pull;
   logic [6:0] adr = 0;
   logic [7:0] wd = 0, rdata, b3;
   int error_cnt = 0, n_compared = 0;
   // open drain lines with pull-ups
   wire logic scl = !(scl_oe | scl_pull);
   wire logic sda = !(sda_oe | sda_pull);
   // rows: offset, write value, expected read back
   logic [22:0] rows [9] = '{{7'h12, 8'hA5, 8'hA5}, {7'h13, 8'h3C, 8'h3C},
      {7'h14, 8'h5A, 8'h5A}, {7'h16, 8'h96, 8'h96}, {7'h17, 8'hFF, 8'h00},
      {7'h15, 8'h1F, 8'h1F}, {7'h02, 8'h10, 8'h10}, {7'h20, 8'h77, 8'h00},
      {7'h00, 8'hF1, 8'h01}};
   always #20 clk = ~clk;
   always #16 lclk = ~lclk;
   sbc_single_channel #(.SAMPLE_CYC_P(50)) i_sbc_single_channel (.core_clk_i(clk),
      .sys_rst_i(rst), .link_clk_i(lclk), .reg_addr_i(adr), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .burst3_byte_o(b3),
      .irq_o(irq), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
      .sda_oe_o(sda_oe));
   sbc_i2c_target #(.ADDR(TADR), .RBYTE(TBYTE)) i_sbc_i2c_target (.scl_i(scl),
      .sda_i(sda), .slow_i(slow), .sda_pull_o(sda_pull), .scl_pull_o(scl_pull));
   // =====================================================================
   // tasks
   task automatic report_and_stop;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         error_cnt++;
      end
   endtask : chk
   task automatic wreg(input logic [6:0] a, input logic [7:0] d);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wreg
   task automatic rreg(input logic [6:0] a, output logic [7:0] d);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask : rreg
   task automatic rchk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] v;
      rreg(a, v);
      chk(v, e);
   endtask : rchk
   // one transfer; irq enabled on reads only, target address may miss, dv is the delay field
   task automatic xfer(input logic r, input logic s, input logic [6:0] ta, input logic [4:0] dv);
      logic [7:0] v, wb;
      int k;
      wb = 8'h69 ^ {r, s, 6'h0};
      wreg(A_SINGLE_WRITE_BYTE, wb);
      wreg(A_SINGLE_TARGET_ADDRESS, {r, ta});
      wreg(A_SINGLE_TARGET_REGISTER, 8'hB4);
      wreg(A_SINGLE_CHANNEL_CONTROL, {1'b1, r, s, dv});
      v = 8'h80;
      for (k = 0; k < 4000 && v[7] !== 1'b0; k++) rreg(A_SINGLE_CHANNEL_CONTROL, v);
      if (k == 4000) begin
         error_cnt++;
         report_and_stop();
      end
      chk(v, {1'b0, r, s, dv});
      repeat (2) @(negedge clk);
      chk({7'h0, irq}, {7'h0, r});
      @(posedge clk);
      rchk(A_SINGLE_STATUS, ta == TADR ? 8'h40 : 8'h50);
      @(negedge clk);
      chk({7'h0, irq}, 8'h00);
      @(posedge clk);
      chk(i_sbc_i2c_target.got[0], {ta, r & s});
      chk(8'(i_sbc_i2c_target.nby), ta != TADR ? 8'd1 : !s ? 8'd3 : r ? 8'd1 : 8'd2);
      if (ta == TADR) begin
         if (!s) chk(i_sbc_i2c_target.got[1], 8'hB4);
         if (!r) chk(i_sbc_i2c_target.got[2 - s], wb);
         if (r && !s) chk(i_sbc_i2c_target.got[2], {ta, 1'b1});
         if (r) rchk(A_SINGLE_READ_BYTE, TBYTE);
      end
      @(posedge clk);
   endtask : xfer
   // =====================================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk(A_BANK_SELECTOR, 8'h00);
      wreg(A_BANK_SELECTOR, 8'h30);
      rchk(A_SINGLE_READ_BYTE, RST_BYTE);
      rchk(A_SINGLE_CHANNEL_CONTROL, RST_BYTE);
      foreach (rows[i]) begin
         wreg(rows[i][22:16], rows[i][15:8]);
         rchk(rows[i][22:16], rows[i][7:0]);
      end
      chk(b3, 8'hA5);
      wreg(A_BANK_SELECTOR, 8'h10);
      rchk(A_SINGLE_TARGET_REGISTER, 8'h00);
      wreg(A_BANK_SELECTOR, 8'h30);
      wreg(A_SINGLE_CHANNEL_CONTROL, 8'h00);
      wreg(A_MASTER_DELAY_CONTROL, 8'h00);
      for (int m = 0; m < 4; m++) xfer(m[1], m[0], TADR, 5'h00);
      slow <= 1'b1;
      xfer(1'b0, 1'b0, TADR, 5'h00);
      slow <= 1'b0;
      xfer(1'b1, 1'b1, 7'h11, 5'h00);
      xfer(1'b0, 1'b1, 7'h11, 5'h00);
      wreg(A_MASTER_DELAY_CONTROL, 8'h10);
      xfer(1'b0, 1'b1, TADR, 5'h03);
      report_and_stop();
   end
endmodule : test_aux_i2c_single_byte_channel
`default_nettype wire
